// file: rtl/ebipt_map.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * 8-bit interval/PWM timer. Assumes inclusion by the timer top module only.
 */
`ifndef EBIPT_MAP_VH
`define EBIPT_MAP_VH

`define EBIPT_OFF_MODE       4'h0
`define EBIPT_OFF_CYCLE      4'h1
`define EBIPT_OFF_DUTY       4'h2
`define EBIPT_OFF_STATUS     4'h3
`define EBIPT_OFF_COUNT      4'h4

`define EBIPT_BIT_RUN        7
`define EBIPT_BIT_CKS_HI     6
`define EBIPT_BIT_CKS_LO     4
`define EBIPT_BIT_MODE_HI    3
`define EBIPT_BIT_MODE_LO    2
`define EBIPT_BIT_LEVEL      1
`define EBIPT_BIT_OUTEN      0

`define EBIPT_RST_MODE       8'h00
`define EBIPT_RST_CYCLE      8'h00
`define EBIPT_RST_DUTY       8'h00

`define EBIPT_MODE_INTERVAL  2'h0
`define EBIPT_MODE_PWM       2'h2

`define EBIPT_CKS_DIV1       3'h0
`define EBIPT_CKS_DIV4       3'h1
`define EBIPT_CKS_DIV16      3'h2
`define EBIPT_CKS_DIV64      3'h3
`define EBIPT_CKS_DIV4096    3'h4
`define EBIPT_CKS_LOWDIV128  3'h5

`define EBIPT_DUTY_SETTLE    2'h3

`endif

// file: rtl/ebipt_timer.v
/*
 * 8-bit interval / PWM timer with register port, prescaler and output pin.
 * Assumes fxpTick and lowClkTick are single-cycle enables on mclk (the
 * peripheral clock rate and the low-speed clock rate), and a bus master
 * that never asserts both strobes together.
 */
// Local design decisions: the strobed register port and the address map.
//
// Function
// - interval cycle match interrupts and clears counter
// - interval mode ignores duty register entirely
// - output enable gives fifty percent square wave
// - interval interrupt every N plus one counts
// - counting starts within one count clock
// - interval match inverts output, clears, interrupts
// - stopping forces interrupt and output inactive
// - PWM cycle match clears, interrupts, goes active
// - PWM duty match goes inactive, no clear
// - PWM period N+1, active width M+1
// - running duty write held until old match
// - held duty needs three count clocks
// - PWM skips first count clock, output inactive
// - duty register writable at any time
// - three-bit select picks prescaled count clock
// - run clear stops and zeroes counter
// - level bit sets default, PWM active opposite
`timescale 1ns/1ps
`include "ebipt_map.vh"

module ebipt_timer #(
    parameter WIDTH = 8
) (
    mclk,
    rstn,
    fxpTick,
    lowClkTick,
    regAddr,
    regWrData,
    regWrStb,
    regRdStb,
    regRdData,
    matchInterrupt,
    timerOutputPin,
    timerOutputOe
);
    input  wire             mclk;
    input  wire             rstn;
    input  wire             fxpTick;
    input  wire             lowClkTick;
    input  wire [3:0]       regAddr;
    input  wire [7:0]       regWrData;
    input  wire             regWrStb;
    input  wire             regRdStb;
    output reg  [7:0]       regRdData;
    output wire             matchInterrupt;
    output wire             timerOutputPin;
    output wire             timerOutputOe;

    reg         rstMeta;
    reg         rstSync;
    reg  [7:0]  modeReg;
    reg  [7:0]  cycleReg;
    reg  [7:0]  dutyHoldReg;
    reg  [7:0]  dutyActReg;
    reg         dutyPendReg;
    reg  [1:0]  dutyAgeReg;
    reg  [11:0] prescReg;
    reg  [6:0]  lowPrescReg;
    reg  [WIDTH-1:0] countReg;
    reg         cmpDutyReg;
    reg         skipReg;
    reg         toggleReg;
    reg         irqReg;
    reg         runDly;

    wire        runBit   = modeReg[`EBIPT_BIT_RUN];
    wire [2:0]  cks      = modeReg[`EBIPT_BIT_CKS_HI:`EBIPT_BIT_CKS_LO];
    wire [1:0]  opMode   = modeReg[`EBIPT_BIT_MODE_HI:`EBIPT_BIT_MODE_LO];
    wire        levelBit = modeReg[`EBIPT_BIT_LEVEL];
    wire        outEnBit = modeReg[`EBIPT_BIT_OUTEN];
    wire        pwmMode  = (opMode == `EBIPT_MODE_PWM);
    wire        wrMode   = regWrStb && (regAddr == `EBIPT_OFF_MODE);
    wire        wrCycle  = regWrStb && (regAddr == `EBIPT_OFF_CYCLE);
    wire        wrDuty   = regWrStb && (regAddr == `EBIPT_OFF_DUTY);

    // four fxp-tick prescaler taps: divide by 2^n is the all-ones low n bits
    function tapHit;
        input [11:0] cnt;
        input [3:0]  n;
        begin
            tapHit = ((cnt | ~((12'h001 << n) - 12'h001)) == 12'hFFF);
        end
    endfunction

    reg cntTick;
    always @* begin
        case (cks)
            `EBIPT_CKS_DIV1:      cntTick = fxpTick;
            `EBIPT_CKS_DIV4:      cntTick = fxpTick && tapHit(prescReg, 4'h2);
            `EBIPT_CKS_DIV16:     cntTick = fxpTick && tapHit(prescReg, 4'h4);
            `EBIPT_CKS_DIV64:     cntTick = fxpTick && tapHit(prescReg, 4'h6);
            `EBIPT_CKS_DIV4096:   cntTick = fxpTick && tapHit(prescReg, 4'hC);
            `EBIPT_CKS_LOWDIV128: cntTick = lowClkTick && (lowPrescReg == 7'h7F);
            default:              cntTick = 1'b0;
        endcase
    end

    wire       countNow  = runBit && cntTick && !skipReg;
    wire       cycMatch  = countNow && !cmpDutyReg && (countReg == cycleReg[WIDTH-1:0]);
    wire       dutyMatch = countNow && pwmMode && cmpDutyReg
                           && (countReg == dutyActReg[WIDTH-1:0]);

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    always @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            prescReg    <= 12'h000;
            lowPrescReg <= 7'h00;
        end else begin
            if (fxpTick)
                prescReg <= prescReg + 12'h001;
            if (lowClkTick)
                lowPrescReg <= lowPrescReg + 7'h01;
        end
    end

    always @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            modeReg  <= `EBIPT_RST_MODE;
            cycleReg <= `EBIPT_RST_CYCLE;
        end else begin
            if (wrMode)
                modeReg <= regWrData;
            if (wrCycle)
                cycleReg <= regWrData;
        end
    end

    // duty path: holding copy takes writes at any time, active copy is
    // loaded when stopped or at a duty match old enough to see the write
    always @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            dutyHoldReg <= `EBIPT_RST_DUTY;
            dutyActReg  <= `EBIPT_RST_DUTY;
            dutyPendReg <= 1'b0;
            dutyAgeReg  <= 2'h0;
        end else begin
            if (wrDuty) begin
                dutyHoldReg <= regWrData;
                dutyPendReg <= 1'b1;
                dutyAgeReg  <= 2'h0;
            end else if (dutyMatch && dutyPendReg && dutyAgeReg == `EBIPT_DUTY_SETTLE) begin
                dutyPendReg <= 1'b0;
            end else if (countNow && dutyAgeReg != `EBIPT_DUTY_SETTLE) begin
                dutyAgeReg <= dutyAgeReg + 2'h1;
            end
            if (!runBit && !wrDuty)
                dutyActReg <= dutyHoldReg;
            else if (dutyMatch && dutyPendReg && !wrDuty
                     && dutyAgeReg == `EBIPT_DUTY_SETTLE)
                dutyActReg <= dutyHoldReg;
        end
    end

    always @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            countReg   <= {WIDTH{1'b0}};
            cmpDutyReg <= 1'b0;
            skipReg    <= 1'b0;
            toggleReg  <= 1'b0;
            irqReg     <= 1'b0;
            runDly     <= 1'b0;
        end else begin
            runDly <= runBit;
            irqReg <= cycMatch;
            if (!runBit) begin
                countReg   <= {WIDTH{1'b0}};
                cmpDutyReg <= 1'b0;
                toggleReg  <= 1'b0;
                skipReg    <= 1'b0;
            end else if (!runDly) begin
                skipReg <= pwmMode;
            end else if (runBit && cntTick && skipReg) begin
                skipReg <= 1'b0;
            end else if (cycMatch) begin
                countReg  <= {WIDTH{1'b0}};
                toggleReg <= !toggleReg;
                if (pwmMode)
                    cmpDutyReg <= 1'b1;
            end else if (dutyMatch) begin
                countReg   <= countReg + {{(WIDTH-1){1'b0}}, 1'b1};
                toggleReg  <= 1'b0;
                cmpDutyReg <= 1'b0;
            end else if (countNow) begin
                countReg <= countReg + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    assign matchInterrupt = irqReg && runBit;
    assign timerOutputPin = outEnBit ? (levelBit ^ toggleReg) : levelBit;
    assign timerOutputOe  = outEnBit;

    always @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            case (regAddr)
                `EBIPT_OFF_MODE:   regRdData <= modeReg;
                `EBIPT_OFF_CYCLE:  regRdData <= cycleReg;
                `EBIPT_OFF_DUTY:   regRdData <= dutyHoldReg;
                `EBIPT_OFF_STATUS: regRdData <= {5'h00, dutyPendReg, cmpDutyReg, toggleReg};
                `EBIPT_OFF_COUNT:  regRdData <= countReg;
                default:           regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule

// file: tb/ebipt_monitor.sv
/* port checker for the timer; assumes fxpTick stays high whenever count select 0 is used */
`timescale 1ns/1ps
module ebipt_monitor (
    input wire       mclk,
    input wire       rstn,
    input wire       fxpTick,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrStb,
    input wire       regRdStb,
    input wire [7:0] regRdData,
    input wire       matchInterrupt,
    input wire       timerOutputPin
);
    reg  [7:0] mode_reg;
    reg  [7:0] cyc_reg;
    reg  [8:0] tick_reg;
    reg  [8:0] run_reg;
    reg  [1:0] stop_reg;
    reg        seen_reg;
    wire       fast = mode_reg[6:2] == 5'h00;
    wire       pwm = mode_reg[3:2] == 2'h2;
    wire [8:0] per = {1'b0, cyc_reg} + 9'h001;
    // shadow registers and cycle counts since the last interrupt, start or stop
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= 8'h00;
            cyc_reg <= 8'h00;
            tick_reg <= 9'h000;
            run_reg <= 9'h000;
            stop_reg <= 2'h0;
            seen_reg <= 1'b0;
        end else begin
            if (regWrStb && regAddr == 4'h0) mode_reg <= regWrData;
            if (regWrStb && regAddr == 4'h1) cyc_reg <= regWrData;
            tick_reg <= matchInterrupt ? 9'h001 : tick_reg + {8'h00, fxpTick};
            run_reg <= mode_reg[7] ? run_reg + 9'h001 : 9'h000;
            stop_reg <= mode_reg[7] ? 2'h0 : stop_reg + {1'b0, stop_reg != 2'h3};
            seen_reg <= mode_reg[7] & (seen_reg | matchInterrupt);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_stop_quiet:
        assert property (stop_reg == 2'h3 |-> !matchInterrupt) else $error("interrupt when stopped");
    a_stop_level:
        assert property (stop_reg == 2'h3 && $stable(mode_reg) |-> timerOutputPin == mode_reg[1])
        else $error("stopped pin not at default level");
    a_int_period:
        assert property (matchInterrupt && seen_reg && mode_reg[6:4] == 3'h0 |-> tick_reg == per)
        else $error("interrupt spacing wrong");
    a_first_int:
        assert property (matchInterrupt && !seen_reg && fast |-> run_reg >= {1'b0, cyc_reg}
            && run_reg <= per + 9'h001) else $error("first interrupt late");
    a_pwm_active:
        assert property (matchInterrupt && pwm && mode_reg[0] |-> ##[0:1]
            timerOutputPin != mode_reg[1]) else $error("pulse not active at cycle match");
    a_sq_flip:
        assert property (matchInterrupt && fast && mode_reg[0] |=>
            timerOutputPin != $past(timerOutputPin, 3)) else $error("no inversion at match");
    a_rd_idle:
        assert property (!$past(regRdStb) || $past(regAddr) > 4'h4 |-> regRdData == 8'h00)
        else $error("read data not zero");
    a_rd_ctrl:
        assert property ($past(regRdStb) && $past(regAddr) < 4'h2 |->
            regRdData == ($past(regAddr) == 4'h0 ? mode_reg : cyc_reg)) else $error("bad readback");
endmodule

// file: tb/ebipt_load.sv
/* load on the timer pin: last high and low times in mclk cycles; pin pulled low when undriven */
`timescale 1ns/1ps
module ebipt_load (
    input  wire       mclk,
    input  wire       pinLevel,
    input  wire       pinOe,
    output reg  [8:0] highWidth,
    output reg  [8:0] lowWidth
);
    reg  [8:0] span_reg = 9'h000;
    reg        last_reg = 1'b0;
    wire       level = pinOe & pinLevel;
    always @(posedge mclk) begin
        if (level != last_reg) begin
            if (last_reg) highWidth <= span_reg;
            else lowWidth <= span_reg;
            span_reg <= 9'h001;
        end else begin
            span_reg <= span_reg + 9'h001;
        end
        last_reg <= level;
    end
endmodule

// file: tb/eight_bit_interval_pwm_timer_tb.sv
/* bench for the timer: register tasks and a cycle model of spacing and widths;
   assumes the checker is bound at the foot of this file */
`timescale 1ns/1ps
module eight_bit_interval_pwm_timer_tb;
    reg        mclk = 1'b0;
    reg        rstn = 1'b0;
    reg        fxpTick = 1'b1;
    reg        lowClkTick = 1'b1;
    reg  [3:0] regAddr = 4'h0;
    reg  [7:0] regWrData = 8'h00;
    reg        regWrStb = 1'b0;
    reg        regRdStb = 1'b0;
    wire [7:0] regRdData;
    wire       matchInterrupt;
    wire       timerOutputPin;
    wire       timerOutputOe;
    wire [8:0] highWidth;
    wire [8:0] lowWidth;
    integer    seed = 32'hfefc;
    integer    mismatches = 0;
    integer    comparisons = 0;
    integer    cycles = 0;
    integer    n, m, lev, k, p;
    ebipt_timer u_dut (.mclk, .rstn, .fxpTick, .lowClkTick, .regAddr, .regWrData, .regWrStb,
        .regRdStb, .regRdData, .matchInterrupt, .timerOutputPin, .timerOutputOe);
    ebipt_load u_load (.mclk, .pinLevel(timerOutputPin), .pinOe(timerOutputOe), .highWidth,
        .lowWidth);
    task chk(input [31:0] g, input [31:0] e); begin
        comparisons = comparisons + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    end endtask
    task wr(input [3:0] a, input [7:0] d); begin
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
    end endtask
    task rd(input [3:0] a, input [7:0] e); begin
        @(posedge mclk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        @(negedge mclk);
        chk(regRdData, e);
    end endtask
    // cycles between two successive interrupts
    task gapw(output integer c); begin
        c = 0;
        while (matchInterrupt !== 1'b1 && c < 20000) begin @(negedge mclk); c = c + 1; end
        @(negedge mclk);
        c = 1;
        while (matchInterrupt !== 1'b1 && c < 20000) begin @(negedge mclk); c = c + 1; end
    end endtask
    task give_verdict; begin
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end endtask
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 80000) begin
            mismatches = mismatches + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (k = 0; k < 5; k = k + 1) rd(k == 3 ? 4'hF : k[3:0], 8'h00);
        n = 3 + {$random(seed)} % 28;
        wr(4'h1, n[7:0]);
        wr(4'h2, 8'hFF);
        wr(4'h0, 8'h81);
        rd(4'h1, n[7:0]);
        gapw(p);
        chk(p, n + 1);
        repeat (2 * n + 2) @(negedge mclk);
        chk(highWidth, n + 1);
        chk(lowWidth, n + 1);
        wr(4'h0, 8'h01);
        repeat (3) @(negedge mclk);
        chk({matchInterrupt, timerOutputPin}, 0);
        rd(4'h4, 8'h00);
        for (lev = 0; lev < 2; lev = lev + 1) begin
            n = 4 + {$random(seed)} % 40;
            m = {$random(seed)} % n;
            wr(4'h1, n[7:0]);
            wr(4'h2, m[7:0]);
            wr(4'h0, 8'h89 | {6'h00, lev[0], 1'b0});
            gapw(p);
            chk(p, n + 1);
            repeat (2 * n + 2) @(negedge mclk);
            chk(lev != 0 ? lowWidth : highWidth, m + 1);
            m = {$random(seed)} % n;
            wr(4'h2, m[7:0]);
            repeat (4 * n + 8) @(negedge mclk);
            chk(highWidth + lowWidth, n + 1);
            chk(lev != 0 ? lowWidth : highWidth, m + 1);
            wr(4'h0, 8'h00);
        end
        wr(4'h1, 8'h03);
        for (k = 0; k < 6; k = k + 1) begin
            wr(4'h0, {1'b1, k[2:0], 4'h0});
            gapw(p);
            chk(p, 4 * (k == 5 ? 128 : 1 << (k == 4 ? 12 : 2 * k)));
            wr(4'h0, 8'h00);
        end
        give_verdict;
    end
endmodule
bind ebipt_timer ebipt_monitor u_mon (.mclk, .rstn, .fxpTick, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .matchInterrupt, .timerOutputPin);
